// *** hw/csb_pkg.sv ***
package csb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] CSB_OFF_CTRL0  = 5'h00;
  localparam logic [4:0] CSB_OFF_TIMING = 5'h04;
  localparam logic [4:0] CSB_OFF_LENGTH = 5'h08;
  localparam logic [4:0] CSB_OFF_STATUS = 5'h0C;
  localparam logic [4:0] CSB_OFF_TXDATA = 5'h10;
  localparam logic [4:0] CSB_OFF_RXDATA = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSB_C0_PWR  = 7;
  localparam int CSB_C0_TXE  = 6;
  localparam int CSB_C0_RXE  = 5;
  localparam int CSB_C0_DIR  = 4;
  localparam int CSB_C0_CONT = 1;
  localparam int CSB_C0_SCE  = 0;
  localparam int CSB_C1_CKP  = 4;
  localparam int CSB_C1_DAP  = 3;
  localparam int CSB_ST_BUSY = 7;
  localparam int CSB_ST_OVE  = 0;

  // ----------------------------------------------------------------
  // Masks, reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CSB_CTRL0_MASK  = 8'hF3;
  localparam logic [7:0]  CSB_TIMING_MASK = 8'h1F;
  localparam logic [7:0]  CSB_LENGTH_MASK = 8'h0F;
  localparam logic [7:0]  CSB_RST_REG     = 8'h00;
  localparam logic [15:0] CSB_RST_DATA    = 16'h0000;
  localparam logic [31:0] CSB_RD_ZERO     = 32'h0000_0000;
  localparam logic [2:0]  CSB_CKS_BRG     = 3'h6;
  localparam logic [2:0]  CSB_CKS_SLAVE   = 3'h7;
  localparam logic [4:0]  CSB_LEN_BASE    = 5'h08;
  localparam logic [4:0]  CSB_LEN_MAX     = 5'h10;
  localparam logic [4:0]  CSB_ONE_BIT     = 5'h01;
  localparam logic [7:0]  CSB_DIV_ONE     = 8'h01;
  localparam logic [7:0]  CSB_BRG_HALF    = 8'h40;

endpackage

// *** hw/csb_serial_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - Busy sets on transmit data write, or on dummy receive read for reception
// - Busy clears on the final serial clock edge of a transfer
// - Overrun sets when a reception completes while receive data is still unread
// - Overrun is detected in single mode even transmit-only; in continuous mode only when receiving
// - Writing 0 clears overrun; writing 1 does nothing
// - Single mode ignores transmit writes while busy, transfer undisturbed
// - Two requests: receive-complete (higher priority) and transmit-ready (lower)
// - Receive-complete pulses whenever received data enters the receive register
// - Receive-complete also pulses when an overrun occurs
// - Single mode pulses receive-complete at completion, even transmit-only
// - Continuous transmit modes pulse transmit-ready when data enters shifter
// - Single modes never pulse transmit-ready
// - Slave mode waits for external clock, then shifts data out with it
// - Single slave transmit ends: output stops, receive-complete, busy clears
// - Clock code 000 is master at half base clock; 111 is slave
// - Order 0 is MSB first; phase 00 is type 1; length 0000 is 8 bits
// - Continuous mode chains a transmit written while busy
// - Overrun overwrites receive data register with new data
// - Power bit clear resets busy and overrun like system reset
module csb_serial_top #(
  parameter logic [7:0] BRG_HALF = csb_pkg::CSB_BRG_HALF
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  output logic             serial_out_pin_o,
  input  wire logic        serial_in_pin_i,
  output logic             rx_done_irq_o,
  output logic             tx_ready_irq_o
);
  import csb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  timing;
    logic [7:0]  length;
    logic [15:0] tx_buf;
    logic        tx_pend;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [15:0] rx_data;
    logic        rx_full;
    logic        busy;
    logic        ove;
    logic [4:0]  cnt;
    logic [7:0]  div;
    logic        sck;
    logic        sck_oe;
    logic        so;
    logic [31:0] rdata;
    logic        wreq;
    logic        irq_r;
    logic        irq_t;
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_s3;
    logic        si_s1;
    logic        si_s2;
  } csb_state_s;

  csb_state_s q;
  csb_state_s n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] bit_len(input logic [7:0] len_reg);
    bit_len = len_reg[3] ? CSB_LEN_MAX : CSB_LEN_BASE + {2'b00, len_reg[2:0]};
  endfunction

  // Bit idx of the frame; data sits from the LSB whatever the order
  function automatic logic tx_bit(input logic [15:0] d, input logic [4:0] idx,
                                  input logic [4:0] len, input logic lsb_first);
    logic [4:0] pos;
    pos = lsb_first ? idx : len - CSB_ONE_BIT - idx;
    tx_bit = d[pos[3:0]];
  endfunction

  function automatic csb_state_s load_shift(input csb_state_s s, input logic [15:0] d);
    csb_state_s r;
    r         = s;
    r.tx_sh   = d;
    r.rx_sh   = CSB_RST_DATA;
    r.cnt     = '0;
    r.div     = '0;
    r.busy    = 1'b1;
    r.sck     = ~s.timing[CSB_C1_CKP];
    if (s.timing[CSB_C1_DAP])
    begin
      r.so = tx_bit(d, '0, bit_len(s.length), s.ctrl0[CSB_C0_DIR]);
    end
    // Only continuous transmit signals a free transmit register
    if (s.ctrl0[CSB_C0_CONT] && s.ctrl0[CSB_C0_TXE])
    begin
      r.irq_t = 1'b1;
    end
    load_shift = r;
  endfunction

  logic [4:0] len;
  logic       master;
  logic       pwr;
  logic [7:0] half;
  logic       lead;
  logic       trail;
  logic       sel;
  logic       acc;

  always_comb
  begin
    n        = q;
    n.irq_r  = 1'b0;
    n.irq_t  = 1'b0;
    len      = bit_len(q.length);
    pwr      = q.ctrl0[CSB_C0_PWR];
    master   = q.timing[2:0] != CSB_CKS_SLAVE;
    half     = (q.timing[2:0] == CSB_CKS_BRG) ? BRG_HALF : CSB_DIV_ONE << q.timing[2:0];
    lead     = 1'b0;
    trail    = 1'b0;
    sel      = avs_byteenable_i[0];
    acc      = (avs_read_i || avs_write_i) && !q.wreq;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    n.sck_s1 = serial_clock_pin_i;
    n.sck_s2 = q.sck_s1;
    n.sck_s3 = q.sck_s2;
    n.si_s1  = serial_in_pin_i;
    n.si_s2  = q.si_s1;

    // ----------------------------------------------------------------
    // Avalon slave: answer one cycle after the request is seen
    // ----------------------------------------------------------------
    n.wreq = 1'b1;
    if ((avs_read_i || avs_write_i) && q.wreq)
    begin
      n.wreq  = 1'b0;
      n.rdata = CSB_RD_ZERO;
      case (avs_address_i)
        CSB_OFF_CTRL0:  n.rdata[7:0] = q.ctrl0;
        CSB_OFF_TIMING: n.rdata[7:0] = q.timing;
        CSB_OFF_LENGTH: n.rdata[7:0] = q.length;
        CSB_OFF_STATUS:
        begin
          n.rdata[CSB_ST_BUSY] = q.busy;
          n.rdata[CSB_ST_OVE]  = q.ove;
        end
        CSB_OFF_TXDATA: n.rdata[15:0] = q.tx_buf;
        CSB_OFF_RXDATA: n.rdata[15:0] = q.rx_data;
        default:        n.rdata = CSB_RD_ZERO;
      endcase
    end

    if (acc && avs_write_i && sel)
    begin
      case (avs_address_i)
        CSB_OFF_CTRL0:  n.ctrl0 = avs_writedata_i[7:0] & CSB_CTRL0_MASK;
        // Timing and length are frozen while the unit is powered
        CSB_OFF_TIMING: if (!pwr) n.timing = avs_writedata_i[7:0] & CSB_TIMING_MASK;
        CSB_OFF_LENGTH: if (!pwr) n.length = avs_writedata_i[7:0] & CSB_LENGTH_MASK;
        CSB_OFF_STATUS: if (!avs_writedata_i[CSB_ST_OVE]) n.ove = 1'b0;
        CSB_OFF_TXDATA:
        begin
          if (!q.busy)
          begin
            n.tx_buf = avs_writedata_i[15:0];
            if (pwr && q.ctrl0[CSB_C0_TXE])
            begin
              n = load_shift(n, avs_writedata_i[15:0]);
            end
          end
          else if (q.ctrl0[CSB_C0_CONT])
          begin
            n.tx_buf  = avs_writedata_i[15:0];
            n.tx_pend = 1'b1;
          end
          // Single mode while busy: write dropped, shifter untouched
        end
        default: ;
      endcase
    end

    if (acc && avs_read_i && avs_address_i == CSB_OFF_RXDATA)
    begin
      n.rx_full = 1'b0;
      // Dummy read starts a receive-only transfer
      if (pwr && q.ctrl0[CSB_C0_RXE] && !q.ctrl0[CSB_C0_TXE] && q.ctrl0[CSB_C0_SCE] && !q.busy)
      begin
        n = load_shift(n, q.tx_buf);
      end
    end

    // ----------------------------------------------------------------
    // Serial clock edges: own divider in master, sampled pin in slave
    // ----------------------------------------------------------------
    if (master)
    begin
      if (q.busy)
      begin
        n.div = q.div + CSB_DIV_ONE;
        if (n.div >= half)
        begin
          n.div = '0;
          n.sck = ~q.sck;
          lead  = q.sck == ~q.timing[CSB_C1_CKP];
          trail = !lead;
        end
      end
    end
    else if (q.busy && q.sck_s2 != q.sck_s3)
    begin
      lead  = q.sck_s3 == ~q.timing[CSB_C1_CKP];
      trail = !lead;
    end

    // ----------------------------------------------------------------
    // Shift engine
    // ----------------------------------------------------------------
    if (lead)
    begin
      if (q.timing[CSB_C1_DAP])
      begin
        n.rx_sh = q.ctrl0[CSB_C0_DIR] ? (q.rx_sh | (16'h0001 << q.cnt[3:0]))
                                      : {q.rx_sh[14:0], 1'b0};
        n.rx_sh[q.ctrl0[CSB_C0_DIR] ? q.cnt[3:0] : 4'h0] = q.si_s2;
      end
      else
      begin
        n.so = tx_bit(q.tx_sh, q.cnt, len, q.ctrl0[CSB_C0_DIR]);
      end
    end

    if (trail)
    begin
      if (!q.timing[CSB_C1_DAP])
      begin
        n.rx_sh = q.ctrl0[CSB_C0_DIR] ? q.rx_sh : {q.rx_sh[14:0], 1'b0};
        n.rx_sh[q.ctrl0[CSB_C0_DIR] ? q.cnt[3:0] : 4'h0] = q.si_s2;
      end
      n.cnt = q.cnt + CSB_ONE_BIT;
      if (n.cnt != len && q.timing[CSB_C1_DAP])
      begin
        n.so = tx_bit(q.tx_sh, n.cnt, len, q.ctrl0[CSB_C0_DIR]);
      end
      if (n.cnt == len)
      begin
        n.busy = 1'b0;
        // Receive register updated in single mode always, continuous only when receiving
        if (!q.ctrl0[CSB_C0_CONT] || q.ctrl0[CSB_C0_RXE])
        begin
          n.rx_data = n.rx_sh;
          n.irq_r   = 1'b1;
          if (n.rx_full)
          begin
            n.ove = 1'b1;
          end
          n.rx_full = 1'b1;
        end
        if (q.ctrl0[CSB_C0_CONT])
        begin
          if (n.tx_pend && q.ctrl0[CSB_C0_TXE])
          begin
            n.tx_pend = 1'b0;
            n = load_shift(n, n.tx_buf);
          end
          else if (!q.ctrl0[CSB_C0_TXE] && q.ctrl0[CSB_C0_RXE] && q.ctrl0[CSB_C0_SCE])
          begin
            // Receive-only continuous restarts without waiting for a read
            n = load_shift(n, n.tx_buf);
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // Power off: status back to reset state
    // ----------------------------------------------------------------
    n.sck_oe = n.ctrl0[CSB_C0_PWR] && n.timing[2:0] != CSB_CKS_SLAVE;
    if (!n.ctrl0[CSB_C0_PWR])
    begin
      n.busy    = 1'b0;
      n.ove     = 1'b0;
      n.tx_pend = 1'b0;
      n.cnt     = '0;
      n.div     = '0;
      n.irq_t   = 1'b0;
    end
    if (!n.busy)
    begin
      n.sck = ~n.timing[CSB_C1_CKP];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      q        <= '0;
      q.ctrl0  <= CSB_RST_REG;
      q.timing <= CSB_RST_REG;
      q.length <= CSB_RST_REG;
      q.wreq   <= 1'b1;
      q.sck    <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign avs_readdata_o        = q.rdata;
  assign avs_waitrequest_o     = q.wreq;
  assign serial_clock_pin_o    = q.sck;
  assign serial_clock_pin_oe_o = q.sck_oe;
  assign serial_out_pin_o      = q.so;
  assign rx_done_irq_o         = q.irq_r;
  assign tx_ready_irq_o        = q.irq_t;

endmodule // csb_serial_top

// *** verif/csb_serial_props.sv ***
`timescale 1ns/1ps
module csb_serial_props (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        serial_clock_pin_i,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_o,
  input wire logic        rx_done_irq_o,
  input wire logic        tx_ready_irq_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  // Shadow copies of the config registers, taken at the write's effect edge
  logic [7:0] c0;
  logic [4:0] tim;
  logic [3:0] len;
  logic [3:0] since_rise;
  logic [4:0] rises;
  logic       wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      c0 <= 8'h00;
      tim <= 5'h00;
      len <= 4'h0;
      since_rise <= 4'hF;
      rises <= 5'h00;
    end
    else
    begin
      if (wr_ok && avs_address_i == 5'h00)
        c0 <= avs_writedata_i[7:0] & 8'hF3;
      // Timing and length are frozen while powered
      if (wr_ok && avs_address_i == 5'h04 && !c0[7])
        tim <= avs_writedata_i[4:0];
      if (wr_ok && avs_address_i == 5'h08 && !c0[7])
        len <= avs_writedata_i[3:0];
      since_rise <= $rose(serial_clock_pin_i) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hF};
      rises <= (rx_done_irq_o || !serial_clock_pin_oe_o) ? 5'h00 : rises + 5'($rose(serial_clock_pin_o));
    end
  end
  property p_rx_pulse;
    rx_done_irq_o |=> !rx_done_irq_o;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq too long");
  property p_tx_pulse;
    tx_ready_irq_o |=> !tx_ready_irq_o;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx irq too long");
  property p_single_quiet;
    !c0[1] |-> !tx_ready_irq_o;
  endproperty
  a_single_quiet: assert property (p_single_quiet) else $error("tx irq in single mode");
  property p_oe_mode;
    $stable({c0[7], tim[2:0]}) |-> serial_clock_pin_oe_o == (c0[7] && tim[2:0] != 3'h7);
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("clock drive wrong for mode");
  property p_half_clk;
    tim == 5'h00 && serial_clock_pin_oe_o && $fell(serial_clock_pin_o) |=> $rose(serial_clock_pin_o);
  endproperty
  a_half_clk: assert property (p_half_clk) else $error("clock not half base");
  property p_bit_count;
    rx_done_irq_o && serial_clock_pin_oe_o |->
      rises + 5'($rose(serial_clock_pin_o)) == (len[3] ? 5'h10 : {1'b0, len} + 5'h08);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("wrong bit count");
  property p_end_high;
    rx_done_irq_o && serial_clock_pin_oe_o && !tim[4] |-> serial_clock_pin_o;
  endproperty
  a_end_high: assert property (p_end_high) else $error("end not on last edge");
  property p_slave_done;
    rx_done_irq_o && !serial_clock_pin_oe_o |-> since_rise <= 4'h6;
  endproperty
  a_slave_done: assert property (p_slave_done) else $error("slave end off edge");
  c_slave_end: cover property (rx_done_irq_o && !serial_clock_pin_oe_o);
  c_master_end: cover property (rx_done_irq_o && serial_clock_pin_oe_o);
  c_tx_ready: cover property (tx_ready_irq_o);
endmodule // csb_serial_props
bind csb_serial_top csb_serial_props u_csb_serial_props (.clk_sys_i, .srst_i, .avs_address_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .serial_clock_pin_i, .serial_clock_pin_o,
  .serial_clock_pin_oe_o, .rx_done_irq_o, .tx_ready_irq_o);

// *** verif/csb_far_end.sv ***
`timescale 1ns/1ps
module csb_far_end (
  input  wire logic sck_dev_i,
  input  wire logic oe_i,
  input  wire logic so_i,
  output logic      sck_o = 1'b1,
  output logic      si_o = 1'b0
);
  logic [15:0] sh = 16'h0000;
  logic [15:0] rcv = 16'h0000;
  // Follows whichever side owns the clock, type 1 only
  wire         ln = oe_i ? sck_dev_i : sck_o;
  always @(negedge ln)
  begin
    si_o <= sh[15];
    sh <= {sh[14:0], 1'b0};
  end
  always @(posedge ln)
    rcv <= {rcv[14:0], so_i};
  // Clock stands high between frames
  task automatic frame(input int n);
    repeat (n)
    begin
      #43 sck_o = 1'b0;
      #40 sck_o = 1'b1;
    end
    #40 si_o = ~si_o;
  endtask
endmodule // csb_far_end

// *** verif/csb_serial_top_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, a) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s exp %0h got %0h", nm, e, a); \
    end \
  end
module csb_serial_top_test;
  import csb_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o, exp_rd, seed = 32'h6748BE71;
  logic        avs_waitrequest_o, serial_clock_pin_o, serial_clock_pin_oe_o, serial_out_pin_o;
  logic        rx_done_irq_o, tx_ready_irq_o, far_sck, far_si;
  logic [31:0] rq[$];
  logic [4:0]  offs[7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
  int          num_errors = 0, num_checks = 0, n_rx = 0, n_tx = 0, cyc = 0;
  csb_serial_top u_csb_serial_top (.clk_sys_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .serial_clock_pin_i(far_sck),
    .serial_clock_pin_o, .serial_clock_pin_oe_o, .serial_out_pin_o, .serial_in_pin_i(far_si),
    .rx_done_irq_o, .tx_ready_irq_o);
  csb_far_end u_csb_far_end (.sck_dev_i(serial_clock_pin_o), .oe_i(serial_clock_pin_oe_o),
    .so_i(serial_out_pin_o), .sck_o(far_sck), .si_o(far_si));
  always #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_rx(input int n);
    repeat (400) if (n_rx < n) @(posedge clk_sys_i);
    `CHK("rx irq count", n, n_rx)
  endtask
  // Monitor takes the oldest noted read value at each answer
  always @(posedge clk_sys_i)
  begin
    n_rx += int'(rx_done_irq_o === 1'b1);
    n_tx += int'(tx_ready_irq_o === 1'b1);
    if (avs_read_i && avs_waitrequest_o === 1'b0)
    begin
      exp_rd = rq.pop_front();
      `CHK("readdata", exp_rd, avs_readdata_o)
    end
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    foreach (offs[i]) rd(offs[i], 8'h00);
    $display("test reset done");
    wr(CSB_OFF_LENGTH, 8'h00);
    // Receive needs code 010 or slower: input sync lag outruns a half period of two cycles or less
    wr(CSB_OFF_TIMING, 8'h02);
    wr(CSB_OFF_CTRL0, 8'hE0);
    for (int k = 0; k < 3; k++)
    begin
      seed = nxt(seed);
      u_csb_far_end.sh = {seed[15:8], 8'h00};
      wr(CSB_OFF_TXDATA, seed[7:0]);
      wr(CSB_OFF_TXDATA, ~seed[7:0]);
      rd(CSB_OFF_STATUS, 8'h80);
      wait_rx(k + 1);
      `CHK("far rx", seed[7:0], u_csb_far_end.rcv[7:0])
      rd(CSB_OFF_STATUS, {7'h0, k == 2});
      if (k != 1) rd(CSB_OFF_RXDATA, seed[15:8]);
      if (k == 0) wr(CSB_OFF_CTRL0, 8'hC0);
    end
    wr(CSB_OFF_STATUS, 8'hFF);
    rd(CSB_OFF_STATUS, 8'h01);
    wr(CSB_OFF_STATUS, 8'h00);
    rd(CSB_OFF_STATUS, 8'h00);
    $display("test single master done");
    wr(CSB_OFF_CTRL0, 8'h00);
    wr(CSB_OFF_TIMING, 8'h00);
    wr(CSB_OFF_CTRL0, 8'hE2);
    seed = nxt(seed);
    wr(CSB_OFF_TXDATA, seed[7:0]);
    wr(CSB_OFF_TXDATA, seed[15:8]);
    wait_rx(5);
    `CHK("chained", {seed[7:0], seed[15:8]}, u_csb_far_end.rcv)
    `CHK("tx irq count", 2, n_tx)
    rd(CSB_OFF_RXDATA, 8'h00);
    rd(CSB_OFF_STATUS, 8'h01);
    wr(CSB_OFF_CTRL0, 8'h00);
    rd(CSB_OFF_STATUS, 8'h00);
    $display("test continuous done");
    wr(CSB_OFF_TIMING, 8'h07);
    wr(CSB_OFF_LENGTH, 8'h00);
    wr(CSB_OFF_CTRL0, 8'hC1);
    seed = nxt(seed);
    u_csb_far_end.sh = {seed[15:8], 8'h00};
    wr(CSB_OFF_TXDATA, seed[7:0]);
    repeat (30) @(posedge clk_sys_i);
    rd(CSB_OFF_STATUS, 8'h80);
    u_csb_far_end.frame(8);
    wait_rx(6);
    `CHK("slave out", seed[7:0], u_csb_far_end.rcv[7:0])
    rd(CSB_OFF_STATUS, 8'h00);
    wr(CSB_OFF_TXDATA, seed[15:8]);
    rd(CSB_OFF_STATUS, 8'h80);
    wr(CSB_OFF_CTRL0, 8'h00);
    rd(CSB_OFF_STATUS, 8'h00);
    $display("test slave done");
    end_sim();
  end
endmodule // csb_serial_top_test
